// ==== core/qdcp_regs.sv ====
// Functional notes
// - no-operation control function changes no state; host uses it as readback filler.
// - clear function loads every DAC register with clear code, updating outputs.
// - load function moves buffered input values into DAC registers, updating outputs.
// - serial-output-off bit disables serial data driver; enabled after reset.
// - clamp bit set (default): overcurrent channel stays powered, current limited 20 mA.
// - clamp bit clear: overcurrent channel powers itself down.
// - thermal shutdown arm bit enables over-temperature shutdown; disarmed after reset.
// - clear value select 0 gives 0 V; 1 midscale or negative full scale.
// - power register selected when register select field equals 010.
// - per-channel power-up bits: set runs channel, clear powers down; reset down.
// - automatic overcurrent power-down clears that channel's power-up bit.
// - reference power-up bit enables internal reference; powered down after reset.
// - over-temperature event powers down all channels and sets thermal alert flag.
// - per-channel read-only overcurrent flags follow condition; writes ignored.
// - power data: oc flags 10..7, bit 6 zero, thermal 5, ref 4, pu 3..0.
// - control register select 011; function 000 nop, 001 config, 100 clear, 101 load.
// - config data: bit3 thermal arm, bit2 clamp, bit1 clear select, bit0 serial off.
// - in clamp mode overcurrent flag clears once the short is removed.
`timescale 1ns/10ps
`include "qdcp_params.svh"
module qdcp_regs (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_sdin,
  input wire logic [3:0] i_overcurrent,
  input wire logic i_overtemp,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic [3:0] o_chan_power_en,
  output logic o_ref_power_en,
  output logic o_clamp_mode,
  output logic o_thermal_arm,
  output logic o_clear_value_select,
  output logic o_clear_pulse,
  output logic o_load_pulse,
  output logic o_frame_valid,
  output logic [23:0] o_frame_word
);
  localparam logic [4:0] FRAME_LEN = 5'(`QDCP_FRAME_BITS);

  logic [7:0] sync_bus;
  logic sclk_s;
  logic sync_n_s;
  logic sdin_s;
  logic [3:0] oc_sync;
  logic ot_sync;

  // all serial pins and analog fault lines enter through two flops; reset clears both flops to 0
  qdcp_sync #(.W(8)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_sclk, i_sync_n, i_sdin, i_overcurrent, i_overtemp}),
    .o_sync(sync_bus)
  );

  assign {sclk_s, sync_n_s, sdin_s, oc_sync, ot_sync} = sync_bus;

  // frame engine state
  qdcp_pkg::qdcp_state_e state_reg;
  qdcp_pkg::qdcp_state_e state_next;
  logic sclk_d_reg;
  logic sync_d_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  qdcp_pkg::qdcp_frame_t shin_reg;
  qdcp_pkg::qdcp_frame_t shin_next;
  qdcp_pkg::qdcp_frame_t sdo_reg;
  qdcp_pkg::qdcp_frame_t sdo_next;
  qdcp_pkg::qdcp_frame_t rdbk_reg;
  qdcp_pkg::qdcp_frame_t rdbk_next;
  logic sdo_oe_next;

  // register state
  logic [3:0] cfg_reg;
  logic [3:0] cfg_next;
  logic [3:0] pu_reg;
  logic [3:0] pu_next;
  logic ref_reg;
  logic ref_next;
  logic tsd_flag_reg;
  logic tsd_flag_next;
  logic [3:0] oc_flag_reg;
  logic [3:0] oc_flag_next;
  logic clr_next;
  logic load_next;
  logic fv_next;
  logic [23:0] fw_next;

  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic exec;
  logic ex_wr;
  logic [2:0] ex_reg;
  logic [2:0] ex_fn;
  logic [15:0] ex_data;
  logic ot_event;
  logic [3:0] oc_trip;

  function automatic logic [15:0] power_word(input logic [3:0] oc, input logic thermal_alert_flag,
                                             input logic refp, input logic [3:0] pu);
    power_word = {5'h00, oc, 1'b0, thermal_alert_flag, refp, pu};
  endfunction

  assign sclk_fall = sclk_d_reg & ~sclk_s;
  assign sync_fall = sync_d_reg & ~sync_n_s;
  assign sync_rise = ~sync_d_reg & sync_n_s;
  assign exec = (state_reg == qdcp_pkg::ST_EXEC);
  assign ex_wr = ~shin_reg[`QDCP_RW_BIT];
  assign ex_reg = shin_reg[`QDCP_REG_MSB:`QDCP_REG_LSB];
  assign ex_fn = shin_reg[`QDCP_ADDR_MSB:`QDCP_ADDR_LSB];
  assign ex_data = shin_reg[`QDCP_DATA_MSB:0];
  // shutdown only acts while armed
  assign ot_event = ot_sync & cfg_reg[`QDCP_CFG_TSD_BIT];
  // trip only without clamp; clamped channels keep running at the limit
  assign oc_trip = oc_sync & {4{~cfg_reg[`QDCP_CFG_CLAMP_BIT]}};

  // frame engine: data sampled on falling sclk, readback shifted on the same edge
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shin_next = shin_reg;
    sdo_next = sdo_reg;
    unique case (state_reg)
      qdcp_pkg::ST_IDLE: begin
        if (sync_fall) begin
          state_next = qdcp_pkg::ST_SHIFT;
          cnt_next = 5'h00;
          sdo_next = rdbk_reg;
        end
      end
      qdcp_pkg::ST_SHIFT: begin
        if (sync_rise) begin
          // a short or long frame is dropped whole
          state_next = (cnt_reg == FRAME_LEN) ? qdcp_pkg::ST_EXEC : qdcp_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          shin_next = {shin_reg[22:0], sdin_s};
          sdo_next = {sdo_reg[22:0], 1'b0};
          if (cnt_reg != 5'h1f) begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      qdcp_pkg::ST_EXEC: begin
        state_next = qdcp_pkg::ST_IDLE;
      end
    endcase
    sdo_oe_next = (state_next == qdcp_pkg::ST_SHIFT) && !cfg_reg[`QDCP_CFG_SDOOFF_BIT];
  end

  // register file and fault handling
  always_comb begin
    cfg_next = cfg_reg;
    pu_next = pu_reg;
    ref_next = ref_reg;
    rdbk_next = rdbk_reg;
    clr_next = 1'b0;
    load_next = 1'b0;
    fv_next = 1'b0;
    fw_next = o_frame_word;
    // flags track the live condition, so a removed short clears its flag
    oc_flag_next = oc_sync;
    tsd_flag_next = tsd_flag_reg;
    if (exec) begin
      rdbk_next = '0;
      if (ex_wr && ex_reg == `QDCP_REG_POWER) begin
        pu_next = ex_data[`QDCP_PWR_PU_MSB:0];
        ref_next = ex_data[`QDCP_PWR_REF_BIT];
      end else if (ex_wr && ex_reg == `QDCP_REG_CONTROL) begin
        unique case (ex_fn)
          `QDCP_FN_CONFIG: cfg_next = ex_data[3:0];
          `QDCP_FN_CLEAR: clr_next = 1'b1;
          `QDCP_FN_LOAD: load_next = 1'b1;
          default: cfg_next = cfg_reg;
        endcase
      end else if (ex_wr) begin
        // dac data and range frames are handed on untouched
        fv_next = 1'b1;
        fw_next = shin_reg;
      end else if (ex_reg == `QDCP_REG_POWER) begin
        rdbk_next = {shin_reg[23:16],
                     power_word(oc_flag_reg, tsd_flag_reg, ref_reg, pu_reg)};
        // alert is cleared by reading it, unless still hot while thermal shutdown is armed
        tsd_flag_next = 1'b0;
      end else if (ex_reg == `QDCP_REG_CONTROL && ex_fn == `QDCP_FN_CONFIG) begin
        rdbk_next = {shin_reg[23:16], 12'h000, cfg_reg};
      end else begin
        fv_next = 1'b1;
        fw_next = shin_reg;
      end
    end
    // faults override a host write in the same cycle
    pu_next = pu_next & ~oc_trip;
    if (ot_event) begin
      pu_next = 4'h0;
      tsd_flag_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= qdcp_pkg::ST_IDLE;
      sclk_d_reg <= 1'b0;
      sync_d_reg <= 1'b0; // follows the synchroniser's reset level: no false frame at release
      cnt_reg <= 5'h00;
      shin_reg <= '0;
      sdo_reg <= '0;
      rdbk_reg <= '0;
      o_sdo_oe <= 1'b0;
      cfg_reg <= `QDCP_CFG_RESET;
      pu_reg <= `QDCP_PU_RESET;
      ref_reg <= 1'b0;
      tsd_flag_reg <= 1'b0;
      oc_flag_reg <= 4'h0;
      o_clear_pulse <= 1'b0;
      o_load_pulse <= 1'b0;
      o_frame_valid <= 1'b0;
      o_frame_word <= '0;
    end else begin
      state_reg <= state_next;
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_n_s;
      cnt_reg <= cnt_next;
      shin_reg <= shin_next;
      sdo_reg <= sdo_next;
      rdbk_reg <= rdbk_next;
      o_sdo_oe <= sdo_oe_next;
      cfg_reg <= cfg_next;
      pu_reg <= pu_next;
      ref_reg <= ref_next;
      tsd_flag_reg <= tsd_flag_next;
      oc_flag_reg <= oc_flag_next;
      o_clear_pulse <= clr_next;
      o_load_pulse <= load_next;
      o_frame_valid <= fv_next;
      o_frame_word <= fw_next;
    end
  end

  // outputs are the register bits themselves
  assign o_sdo = sdo_reg[23];
  assign o_chan_power_en = pu_reg;
  assign o_ref_power_en = ref_reg;
  assign o_clamp_mode = cfg_reg[`QDCP_CFG_CLAMP_BIT];
  assign o_thermal_arm = cfg_reg[`QDCP_CFG_TSD_BIT];
  assign o_clear_value_select = cfg_reg[`QDCP_CFG_CLRSEL_BIT];

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic ex_nop;
  logic ex_pwr_wr;
  assign ex_nop = exec && ex_wr && ex_reg == `QDCP_REG_CONTROL && ex_fn == `QDCP_FN_NOP;
  assign ex_pwr_wr = exec && ex_wr && ex_reg == `QDCP_REG_POWER;

  property p_nop_still;
    ex_nop && !ot_event && oc_trip == 4'h0 |=>
      $stable(cfg_reg) && $stable(pu_reg) && $stable(ref_reg) && !o_clear_pulse;
  endproperty
  a_nop_still: assert property (p_nop_still) else $error("nop changed state");

  property p_clear;
    exec && ex_wr && ex_reg == `QDCP_REG_CONTROL && ex_fn == `QDCP_FN_CLEAR
      |=> o_clear_pulse && !o_load_pulse ##1 !o_clear_pulse;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pulse wrong");

  property p_load;
    exec && ex_wr && ex_reg == `QDCP_REG_CONTROL && ex_fn == `QDCP_FN_LOAD
      |=> o_load_pulse && !o_clear_pulse ##1 !o_load_pulse;
  endproperty
  a_load: assert property (p_load) else $error("load pulse wrong");

  property p_sdo_off;
    cfg_reg[`QDCP_CFG_SDOOFF_BIT] && $stable(cfg_reg) |-> !o_sdo_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven while off");

  property p_clamp_keeps;
    o_clamp_mode && oc_sync[1] && pu_reg[1] && !ot_event && !exec |=> pu_reg[1];
  endproperty
  a_clamp_keeps: assert property (p_clamp_keeps) else $error("clamped chan lost power");

  property p_trip;
    !o_clamp_mode && oc_sync[2] |=> !o_chan_power_en[2];
  endproperty
  a_trip: assert property (p_trip) else $error("overcurrent did not power down");

  property p_thermal;
    ot_event |=> o_chan_power_en == 4'h0 && tsd_flag_reg;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal shutdown missed");

  property p_disarmed;
    !o_thermal_arm && !tsd_flag_reg |=> !tsd_flag_reg;
  endproperty
  a_disarmed: assert property (p_disarmed) else $error("alert while disarmed");

  property p_pwr_wr;
    ex_pwr_wr |=> o_ref_power_en == $past(ex_data[`QDCP_PWR_REF_BIT]);
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("reference bit not written");

  property p_oc_clear;
    o_clamp_mode && $fell(oc_sync[1]) |=> !oc_flag_reg[1];
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("oc flag stuck");

  c_pwr_wr: cover property (ex_pwr_wr);
  c_read: cover property (exec && !ex_wr ##[1:300] sync_fall);
  c_thermal: cover property (ot_event);
  c_clear: cover property (o_clear_pulse);
endmodule

// ==== inc/qdcp_params.svh ====
`ifndef QDCP_PARAMS_SVH
`define QDCP_PARAMS_SVH

// serial frame layout
`define QDCP_FRAME_BITS 24
`define QDCP_RW_BIT 23
`define QDCP_REG_MSB 21
`define QDCP_REG_LSB 19
`define QDCP_ADDR_MSB 18
`define QDCP_ADDR_LSB 16
`define QDCP_DATA_MSB 15

// register-select codes
`define QDCP_REG_POWER 3'h2
`define QDCP_REG_CONTROL 3'h3

// control function codes
`define QDCP_FN_NOP 3'h0
`define QDCP_FN_CONFIG 3'h1
`define QDCP_FN_CLEAR 3'h4
`define QDCP_FN_LOAD 3'h5

// configuration data bits
`define QDCP_CFG_TSD_BIT 3
`define QDCP_CFG_CLAMP_BIT 2
`define QDCP_CFG_CLRSEL_BIT 1
`define QDCP_CFG_SDOOFF_BIT 0

// power register data bits
`define QDCP_PWR_OC_MSB 10
`define QDCP_PWR_OC_LSB 7
`define QDCP_PWR_TSD_BIT 5
`define QDCP_PWR_REF_BIT 4
`define QDCP_PWR_PU_MSB 3

// reset values
`define QDCP_CFG_RESET 4'h4
`define QDCP_PU_RESET 4'h0

// channel power-up time the host must allow
`define QDCP_CLK_NS 25
`define QDCP_PWRUP_NS 10000
`define QDCP_PWRUP_CYC ((`QDCP_PWRUP_NS + `QDCP_CLK_NS - 1) / `QDCP_CLK_NS)

`endif

// ==== inc/qdcp_pkg.sv ====
package qdcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_EXEC = 3'h4
  } qdcp_state_e;

  typedef logic [23:0] qdcp_frame_t;
endpackage

// ==== core/qdcp_sync.sv ====
`timescale 1ns/10ps
// two-flop synchroniser bank; stage one feeds stage two only
module qdcp_sync #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= meta_next;
      o_sync <= sync_next;
    end
  end
endmodule

// ==== verif/qdcp_host_model.sv ====
`timescale 1ns/10ps
// host side of the serial link: sclk idles high and stands still between frames
module qdcp_host_model (
  input wire logic i_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdin
);
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_sdin = 1'b0;
  end

  // one 24-bit frame, msb first, 200 ns sclk period at a 25 ns i_clk
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    @(posedge i_clk);
    o_sync_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sdin <= w[i];
      repeat (4) @(posedge i_clk);
      // a released sdo line reads as z so a disabled driver cannot pass for data
      r[i] = i_sdo_oe ? i_sdo : 1'bz;
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (4) @(posedge i_clk);
    o_sync_n <= 1'b1;
    // data line inverted once at frame end so no stale bit looks valid outside a frame
    o_sdin <= ~o_sdin;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ==== verif/qdcp_regs_tb_top.sv ====
`timescale 1ns/10ps
`include "qdcp_params.svh"
`define CHK(n, e, g) check(n, 24'(e), 24'(g))
module qdcp_regs_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] ovc = 4'h0;
  logic ovt = 1'b0;
  logic sclk, sync_n, sdin, sdo, sdo_oe, refen, clamp, tarm, clrsel, clrp, ldp, fv;
  logic [3:0] pen;
  logic [23:0] fw;
  int error_cnt = 0;
  int checked = 0;
  int clr_cnt = 0;
  int ld_cnt = 0;
  int fv_cnt = 0;

  always #12.5 clk = ~clk;

  qdcp_regs uut (.i_clk(clk), .i_reset_n(reset_n), .i_sclk(sclk), .i_sync_n(sync_n),
    .i_sdin(sdin), .i_overcurrent(ovc), .i_overtemp(ovt), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .o_chan_power_en(pen), .o_ref_power_en(refen), .o_clamp_mode(clamp),
    .o_thermal_arm(tarm), .o_clear_value_select(clrsel), .o_clear_pulse(clrp),
    .o_load_pulse(ldp), .o_frame_valid(fv), .o_frame_word(fw));

  qdcp_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk),
    .o_sync_n(sync_n), .o_sdin(sdin));

  // counting high cycles also proves the pulses last one cycle
  always @(posedge clk) begin
    if (clrp === 1'b1) clr_cnt++;
    if (ldp === 1'b1) ld_cnt++;
    if (fv === 1'b1) fv_cnt++;
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [23:0] w);
    logic [23:0] r;
    host.xfer(w, r);
  endtask

  // read frame, then a no-op frame as filler clocks the answer out
  task automatic rd(input string n, input logic [23:0] cmd, input logic [23:0] e);
    logic [23:0] r;
    host.xfer(cmd, r);
    host.xfer(24'h180000, r);
    `CHK(n, e, r);
  endtask

  task automatic wait_pen(input logic [3:0] e);
    int k;
    k = 0;
    while (pen !== e && k < 20) begin
      @(posedge clk);
      k++;
    end
    `CHK("chan_power_en", e, pen);
    if (k >= 20) stop_test();
  endtask

  task automatic t_reset();
    `CHK("chan_power_en", `QDCP_PU_RESET, pen);
    `CHK("ref_power_en", 0, refen);
    `CHK("clamp_mode", 1, clamp);
    `CHK("thermal_arm", 0, tarm);
    `CHK("clear_select", 0, clrsel);
    rd("power_rb", 24'h900000, 24'h900000);
    rd("config_rb", 24'h990000, 24'h990004);
    $display("test reset done");
  endtask

  task automatic t_power();
    wr(24'h10001f);
    `CHK("chan_power_en", 4'hf, pen);
    `CHK("ref_power_en", 1, refen);
    wr(24'h1007da);
    `CHK("chan_power_en", 4'ha, pen);
    rd("power_rb", 24'h900000, 24'h90001a);
    $display("test power done");
  endtask

  task automatic t_cfg();
    logic [23:0] r;
    wr(24'h19000a);
    `CHK("thermal_arm", 1, tarm);
    `CHK("clamp_mode", 0, clamp);
    `CHK("clear_select", 1, clrsel);
    wr(24'h180000);
    `CHK("cfg_after_nop", 3'h5, {tarm, clamp, clrsel});
    rd("config_rb", 24'h990000, 24'h99000a);
    wr(24'h190005);
    host.xfer(24'h990000, r);
    host.xfer(24'h180000, r);
    `CHK("sdo_off", 24'hzzzzzz, r);
    wr(24'h190004);
    $display("test config done");
  endtask

  task automatic t_cmd();
    int c, l, f;
    logic [23:0] r;
    c = clr_cnt;
    l = ld_cnt;
    wr(24'h1c0000);
    `CHK("clear_pulses", 1, clr_cnt - c);
    `CHK("load_pulses", 0, ld_cnt - l);
    repeat (`QDCP_PWRUP_CYC) @(posedge clk);
    wr(24'h1d0000);
    `CHK("load_pulses", 1, ld_cnt - l);
    wr(24'h180000);
    `CHK("pulses_after_nop", 2, clr_cnt - c + ld_cnt - l);
    f = fv_cnt;
    wr(24'h30000f);
    `CHK("frame_valid", 1, fv_cnt - f);
    `CHK("frame_word", 24'h30000f, fw);
    `CHK("chan_power_en", 4'ha, pen);
    host.xfer(24'h800000, r);
    `CHK("frame_valid", 2, fv_cnt - f);
    `CHK("frame_word", 24'h800000, fw);
    $display("test commands done");
  endtask

  task automatic t_fault();
    wr(24'h10001f);
    @(posedge clk);
    ovc <= 4'h2;
    repeat (8) @(posedge clk);
    `CHK("chan_power_en", 4'hf, pen);
    rd("oc_flag", 24'h900000, 24'h90011f);
    ovc <= 4'h0;
    repeat (8) @(posedge clk);
    rd("oc_clear", 24'h900000, 24'h90001f);
    wr(24'h190000);
    ovc <= 4'h4;
    wait_pen(4'hb);
    ovc <= 4'h0;
    repeat (8) @(posedge clk);
    rd("pu_cleared", 24'h900000, 24'h90001b);
    wr(24'h10001f);
    ovt <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("chan_power_en", 4'hf, pen);
    ovt <= 1'b0;
    wr(24'h190008);
    ovt <= 1'b1;
    wait_pen(4'h0);
    ovt <= 1'b0;
    repeat (8) @(posedge clk);
    rd("thermal_flag", 24'h900000, 24'h900030);
    $display("test faults done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_power();
    t_cfg();
    t_cmd();
    t_fault();
    stop_test();
  end
endmodule
